/* core/xmb_defs.vh */
`ifndef XMB_DEFS_VH
`define XMB_DEFS_VH
`define XMB_PERIODS      3'h6
`define XMB_CNT_ONE      3'h1
`define XMB_PH_ADDR      3'h0
`define XMB_PH_ALE_END   3'h1
`define XMB_PH_STB_ON    3'h2
`define XMB_PH_STB_OFF   3'h5
`define XMB_INT_CODE_TOP 16'hF7FF
`define XMB_NOP          8'h00
`define XMB_XRAM_TOP     24'h0007FF
`endif

/* core/xmb_bus.v */
`timescale 1ns/1ps
`include "xmb_defs.vh"
module xmb_bus (
  clock,
  arst_n,
  strapIn,
  strobePinIn,
  latchDisable,
  xramMapEn,
  fetchReq,
  fetchAddr,
  dataReq,
  dataWrite,
  dataAddr,
  dataWdata,
  lowPortReg,
  highPortReg,
  lowPortIn,
  highPortIn,
  extCode,
  downloadMode,
  busRdata,
  busDone,
  intFetch,
  intData,
  nopFetch,
  lowPortOut,
  lowPortOe,
  highPortOut,
  highPortOe,
  highPortWeak,
  latchStrobe,
  latchStrobeOe,
  progStrobeN,
  readStrobeN,
  writeStrobeN
);
  input  wire        clock;
  input  wire        arst_n;
  input  wire        strapIn;
  input  wire        strobePinIn;
  input  wire        latchDisable;
  input  wire        xramMapEn;
  input  wire        fetchReq;
  input  wire [15:0] fetchAddr;
  input  wire        dataReq;
  input  wire        dataWrite;
  input  wire [23:0] dataAddr;
  input  wire [7:0]  dataWdata;
  input  wire [7:0]  lowPortReg;
  input  wire [7:0]  highPortReg;
  input  wire [7:0]  lowPortIn;
  input  wire [7:0]  highPortIn;
  output reg         extCode;
  output reg         downloadMode;
  output reg  [7:0]  busRdata;
  output reg         busDone;
  output reg         intFetch;
  output reg         intData;
  output reg         nopFetch;
  output reg  [7:0]  lowPortOut;
  output reg  [7:0]  lowPortOe;
  output reg  [7:0]  highPortOut;
  output reg  [7:0]  highPortOe;
  output reg  [7:0]  highPortWeak;
  output reg         latchStrobe;
  output reg         latchStrobeOe;
  output reg         progStrobeN;
  output reg         readStrobeN;
  output reg         writeStrobeN;

  localparam ST_IDLE  = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_DATA  = 3'b100;

  // =========================================
  // strap capture
  // =========================================
  reg strapPend_q;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strapPend_q  <= 1'b1;
      extCode      <= 1'b0;
      downloadMode <= 1'b0;
    end else if (strapPend_q) begin
      // first edge after release; strap assumed stable afterwards
      strapPend_q  <= 1'b0;
      extCode      <= ~strapIn;
      downloadMode <= ~strobePinIn;
    end
  end

  // =========================================
  // cycle sequencer
  // =========================================
  reg [2:0]  state_q;
  reg [2:0]  phase_q;
  reg        wr_q;
  reg [23:0] addr_q;
  reg [7:0]  wdata_q;
  wire isXram = xramMapEn && (dataAddr <= `XMB_XRAM_TOP);
  wire lastPh = (phase_q == (`XMB_PERIODS - `XMB_CNT_ONE));
  // one idle edge after any answer so a held request is not taken twice
  wire reqOk  = !strapPend_q && !busDone && !intFetch && !intData;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ST_IDLE;
      phase_q      <= `XMB_PH_ADDR;
      wr_q         <= 1'b0;
      addr_q       <= 24'h000000;
      wdata_q      <= 8'h00;
      busRdata     <= 8'h00;
      busDone      <= 1'b0;
      intFetch     <= 1'b0;
      intData      <= 1'b0;
      nopFetch     <= 1'b0;
      lowPortOut   <= 8'hFF;
      lowPortOe    <= 8'h00;
      highPortOut  <= 8'hFF;
      highPortOe   <= 8'h00;
      highPortWeak <= 8'hFF;
      latchStrobe  <= 1'b0;
      latchStrobeOe <= 1'b1;
      progStrobeN  <= 1'b1;
      readStrobeN  <= 1'b1;
      writeStrobeN <= 1'b1;
    end else begin
      busDone  <= 1'b0;
      intFetch <= 1'b0;
      intData  <= 1'b0;
      nopFetch <= 1'b0;
      latchStrobeOe <= ~latchDisable;
      case (state_q)
        ST_IDLE: begin
          phase_q <= `XMB_PH_ADDR;
          // general I/O: open drain low port, weak high port
          lowPortOut   <= 8'h00;
          lowPortOe    <= ~lowPortReg;
          highPortOut  <= 8'h00;
          highPortOe   <= ~highPortReg;
          highPortWeak <= highPortReg;
          latchStrobe  <= 1'b0;
          progStrobeN  <= 1'b1;
          if (fetchReq && reqOk) begin
            if (extCode) begin
              state_q <= ST_FETCH;
              addr_q  <= {8'h00, fetchAddr};
            end else if (fetchAddr > `XMB_INT_CODE_TOP) begin
              nopFetch <= 1'b1;
              busRdata <= `XMB_NOP;
              busDone  <= 1'b1;
            end else begin
              intFetch <= 1'b1;
            end
          end else if (dataReq && reqOk) begin
            if (isXram) begin
              intData <= 1'b1;
            end else begin
              state_q <= ST_DATA;
              wr_q    <= dataWrite;
              addr_q  <= dataAddr;
              wdata_q <= dataWdata;
            end
          end
        end
        ST_FETCH, ST_DATA: begin
          phase_q <= lastPh ? `XMB_PH_ADDR : phase_q + `XMB_CNT_ONE;
          highPortWeak <= 8'h00;
          highPortOe   <= 8'hFF;
          highPortOut  <= (state_q == ST_FETCH) ? addr_q[15:8]
                          : (phase_q == `XMB_PH_ADDR ? addr_q[23:16]
                                                     : addr_q[15:8]);
          latchStrobe <= (phase_q == `XMB_PH_ADDR) &&
                         (state_q == ST_FETCH || phase_q == `XMB_PH_ADDR);
          if (phase_q == `XMB_PH_ADDR) begin
            lowPortOut <= addr_q[7:0];
            lowPortOe  <= 8'hFF;
          end else if (state_q == ST_DATA && wr_q) begin
            lowPortOut <= wdata_q;
            lowPortOe  <= 8'hFF;
          end else begin
            lowPortOut <= 8'h00;
            lowPortOe  <= 8'h00;
          end
          if (phase_q == `XMB_PH_STB_ON) begin
            if (state_q == ST_FETCH)
              progStrobeN <= 1'b0;
            else if (wr_q)
              writeStrobeN <= 1'b0;
            else
              readStrobeN <= 1'b0;
          end
          if (phase_q == `XMB_PH_STB_OFF) begin
            progStrobeN  <= 1'b1;
            readStrobeN  <= 1'b1;
            writeStrobeN <= 1'b1;
            busRdata     <= lowPortIn;
          end
          if (lastPh) begin
            busDone <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  wire unusedHigh = |highPortIn;
endmodule // xmb_bus

/* test/xmb_bus_properties.sv */
`timescale 1ns/1ps
// ====================
// bus timing checks
module xmb_bus_properties (
  input wire       clock,
  input wire       arst_n,
  input wire       latchDisable,
  input wire       extCode,
  input wire       busDone,
  input wire       intData,
  input wire       nopFetch,
  input wire [7:0] lowPortOe,
  input wire       latchStrobe,
  input wire       latchStrobeOe,
  input wire       progStrobeN,
  input wire       readStrobeN,
  input wire       writeStrobeN
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_int_ps; !extCode |-> progStrobeN; endproperty
  a_int_ps: assert property (p_int_ps) else $error("ps int");
  property p_rd; $fell(readStrobeN) |-> !readStrobeN[*3] ##1 readStrobeN;
  endproperty
  a_rd: assert property (p_rd) else $error("rd len");
  property p_wr; $fell(writeStrobeN) |-> !writeStrobeN[*3] ##1 writeStrobeN;
  endproperty
  a_wr: assert property (p_wr) else $error("wr len");
  property p_ps_ale; $fell(progStrobeN) |-> $past(latchStrobe, 2); endproperty
  a_ps_ale: assert property (p_ps_ale) else $error("ale");
  property p_ps_one; !progStrobeN |-> readStrobeN && writeStrobeN; endproperty
  a_ps_one: assert property (p_ps_one) else $error("ps data");
  property p_drv; latchStrobe |-> lowPortOe == 8'hFF; endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_dis; latchDisable |=> !latchStrobeOe; endproperty
  a_dis: assert property (p_dis) else $error("ale off");
  property p_xram; intData |-> readStrobeN && writeStrobeN && !latchStrobe;
  endproperty
  a_xram: assert property (p_xram) else $error("xram");
  property p_nop; nopFetch |-> busDone && !extCode; endproperty
  a_nop: assert property (p_nop) else $error("nop");
  c_rd: cover property (!readStrobeN);
  c_wr: cover property (!writeStrobeN);
  c_nop: cover property (nopFetch);
endmodule // xmb_bus_properties
bind xmb_bus xmb_bus_properties xmb_bus_properties_inst (.*);

/* test/xmb_mem_model.sv */
`timescale 1ns/1ps
// ====================
// external memory with address latch
module xmb_mem_model (
  input  wire       clock,
  input  wire [7:0] lowPortOut,
  input  wire [7:0] lowPortOe,
  input  wire       latchStrobe,
  input  wire       latchStrobeOe,
  input  wire       progStrobeN,
  input  wire       readStrobeN,
  input  wire       writeStrobeN,
  output wire [7:0] lowPortIn
);
  reg [7:0] mem [0:255];
  reg [7:0] addr_q;
  wire [7:0] drv;
  integer i;
  initial for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
  // last sample before the port turns to data
  always @(posedge clock) if (latchStrobe & latchStrobeOe) addr_q <= lowPortOut;
  always @(posedge clock) if (!writeStrobeN) mem[addr_q] <= lowPortOut;
  // released lines sit at the external pull-up level
  assign drv = (!readStrobeN | !progStrobeN) ? mem[addr_q] : 8'hFF;
  assign lowPortIn = (lowPortOut & lowPortOe) | (drv & ~lowPortOe);
endmodule // xmb_mem_model

/* test/tb.sv */
`timescale 1ns/1ps
// ====================
// bench
module tb;
  reg clock = 0, arst_n = 0, strapIn = 0, strobePinIn = 1;
  reg latchDisable = 0, xramMapEn = 0, fetchReq = 0, dataReq = 0;
  reg dataWrite = 0;
  reg [15:0] fetchAddr = 0;
  reg [23:0] dataAddr = 0, a;
  reg [7:0] dataWdata = 0, lowPortReg = 8'hFF, highPortReg = 8'hFF;
  reg [7:0] highPortIn = 8'hFF, shadow [0:255];
  wire [7:0] lowPortIn, busRdata, lowPortOut, lowPortOe;
  wire [7:0] highPortOut, highPortOe, highPortWeak;
  wire extCode, downloadMode, busDone, intFetch, intData, nopFetch;
  wire latchStrobe, latchStrobeOe, progStrobeN, readStrobeN, writeStrobeN;
  reg [8:0] q [$];
  reg [8:0] e;
  integer fails = 0, comparisons = 0, seed = 31, i, n;
  xmb_bus xmb_bus_inst (.*);
  xmb_mem_model xmb_mem_model_inst (.*);
  initial forever #20 clock = ~clock;
  task stop_test;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] x);
    begin
      comparisons = comparisons + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  // strap held steady between resets
  task rst(input s, input p);
    begin
      arst_n <= 0;
      strapIn <= s;
      strobePinIn <= p;
      repeat (2) @(posedge clock);
      arst_n <= 1;
      repeat (2) @(posedge clock);
      strobePinIn <= 1;
      chk({7'h00, extCode}, {7'h00, !s});
      chk({7'h00, downloadMode}, {7'h00, !p});
    end
  endtask
  task op(input [1:0] k, input [23:0] ad, input [7:0] w, input c,
          input [7:0] x);
    begin
      q.push_back({c, x});
      fetchReq <= k == 0;
      dataReq <= k != 0;
      dataWrite <= k == 2;
      fetchAddr <= ad[15:0];
      dataAddr <= ad;
      dataWdata <= w;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (busDone !== 1'b1 && intData !== 1'b1 && n < 20);
      if (n == 20) begin
        fails = fails + 1;
        stop_test;
      end
      fetchReq <= 0;
      dataReq <= 0;
      @(posedge clock);
    end
  endtask
  // each operation's expected entry leaves the queue as its answer arrives; only fetches and reads are compared
  always @(posedge clock) if (busDone === 1'b1 || intData === 1'b1) begin
    e = q.pop_front();
    if (e[8]) chk(busRdata, e[7:0]);
  end
  initial begin
    for (i = 0; i < 256; i = i + 1) shadow[i] = i[7:0] ^ 8'h5A;
    rst(0, 1);
    for (i = 0; i < 6; i = i + 1) begin
      a = $random(seed);
      lowPortReg <= $random(seed);
      op(0, a, 8'h00, 1, shadow[a[7:0]]);
      op(2, a, a[15:8], 0, 8'h00);
      shadow[a[7:0]] = a[15:8];
      op(1, a, 8'h00, 1, shadow[a[7:0]]);
    end
    rst(1, 0);
    rst(1, 1);
    latchDisable <= 1;
    xramMapEn <= 1;
    op(0, 24'h00F800, 8'h00, 1, 8'h00);
    op(0, 24'h00FFFF, 8'h00, 1, 8'h00);
    op(2, 24'h0007FF, 8'h3C, 0, 8'h00);
    stop_test;
  end
endmodule // tb
